// File: hdl/dsip_pkg.sv
`default_nettype none
package dsip_pkg;
	// ----------------------------------------
	// frame geometry
	// ----------------------------------------
	localparam int unsigned FRAME_BITS   = 16;
	localparam int unsigned CODE_BITS    = 14;
	localparam int unsigned CODE_LSB     = 0;
	localparam int unsigned EDGE_SEL_BIT = 15;
	localparam int unsigned CNT_W        = 5;
	// ----------------------------------------
	// reset values and limits
	// ----------------------------------------
	localparam logic [FRAME_BITS-1:0] SHIFT_RST = 16'h0000;
	localparam logic [CODE_BITS-1:0]  CODE_RST  = 14'h0000;
	localparam logic                  EDGE_RST  = 1'b0;
	localparam logic [CODE_BITS-1:0]  CODE_MAX_12 = 14'h0FFF;
	localparam logic [CODE_BITS-1:0]  CODE_MAX_14 = 14'h3FFF;
	localparam logic [CNT_W-1:0]      CNT_RST   = 5'h00;
	localparam logic [CNT_W-1:0]      CNT_FULL  = 5'h10;
	// ----------------------------------------
	// link timing
	// ----------------------------------------
	localparam real LINK_PERIOD_NS = 200.0;
	localparam real REF_PERIOD_NS  = 25.0;
	localparam int unsigned LINK_HALF_CYC = int'(LINK_PERIOD_NS / 2.0 / REF_PERIOD_NS);
endpackage
`default_nettype wire

// File: hdl/dsip_sync2.sv
`default_nettype none
module dsip_sync2 (
	input  wire logic ref_clk_i,
	input  wire logic rstn_i,
	input  wire logic async_i,
	input  wire logic rst_val_i,
	output var  logic sync_o
);
	logic meta_reg;

	// rst_val_i must be a constant tie-off; reset loads are synchronous
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			meta_reg <= rst_val_i;
			sync_o   <= rst_val_i;
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// File: hdl/dsip_port.sv
`default_nettype none
module dsip_port #(
	parameter int unsigned DAC_BITS = 14
) (
	input  wire logic                           ref_clk_i,
	input  wire logic                           rstn_i,
	input  wire logic                           sclk_i,
	input  wire logic                           frame_n_i,
	input  wire logic                           serial_data_in_i,
	output var  logic                           chain_data_out_o,
	output var  logic [dsip_pkg::CODE_BITS-1:0] dac_code_o,
	output var  logic                           dac_update_o,
	output var  logic                           rise_capture_o
);
	import dsip_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic sclk_s;
	logic frame_n_s;
	logic data_s;

	// serial clock parks high in the default mode; a low reset value would fake an edge
	dsip_sync2 u_sync_sclk (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.async_i   (sclk_i),
		.rst_val_i (1'b1),
		.sync_o    (sclk_s)
	);
	dsip_sync2 u_sync_frame (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.async_i   (frame_n_i),
		.rst_val_i (1'b1),
		.sync_o    (frame_n_s)
	);
	dsip_sync2 u_sync_data (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.async_i   (serial_data_in_i),
		.rst_val_i (1'b0),
		.sync_o    (data_s)
	);

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	logic sclk_d_reg;
	logic frame_d_reg;

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			sclk_d_reg  <= 1'b1;
			frame_d_reg <= 1'b1;
		end else begin
			sclk_d_reg  <= sclk_s;
			frame_d_reg <= frame_n_s;
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic frame_rise;
	logic capture_edge;
	logic launch_edge;
	logic edge_sel_reg;

	assign sclk_rise    = sclk_s & ~sclk_d_reg;
	assign sclk_fall    = ~sclk_s & sclk_d_reg;
	assign frame_rise   = frame_n_s & ~frame_d_reg;
	// default falling capture, rising once selected
	assign capture_edge = edge_sel_reg ? sclk_rise : sclk_fall;
	assign launch_edge  = edge_sel_reg ? sclk_fall : sclk_rise;

	// ----------------------------------------
	// shift register
	// ----------------------------------------
	logic [FRAME_BITS-1:0] shift_reg;
	logic [CNT_W-1:0]      cnt_reg;
	logic                  in_frame;

	assign in_frame = ~frame_n_s;

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			shift_reg <= SHIFT_RST;
		end else if (in_frame && capture_edge) begin
			shift_reg <= {shift_reg[FRAME_BITS-2:0], data_s};
		end
	end

	// counts captures so a short frame is not loaded
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			cnt_reg <= CNT_RST;
		end else if (frame_n_s) begin
			cnt_reg <= CNT_RST;
		end else if (capture_edge && cnt_reg != CNT_FULL) begin
			cnt_reg <= cnt_reg + 5'h01;
		end
	end

	// ----------------------------------------
	// chain output
	// ----------------------------------------
	// msb leaving the register is presented on the launch edge
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			chain_data_out_o <= 1'b0;
		end else if (in_frame && launch_edge) begin
			chain_data_out_o <= shift_reg[FRAME_BITS-1];
		end
	end

	// ----------------------------------------
	// latch update
	// ----------------------------------------
	logic [CODE_BITS-1:0] code_mask;
	logic                 load_ok;

	assign code_mask = (DAC_BITS == 12) ? CODE_MAX_12 : CODE_MAX_14;
	assign load_ok   = frame_rise && (cnt_reg == CNT_FULL);

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			dac_code_o   <= CODE_RST;
			dac_update_o <= 1'b0;
		end else begin
			dac_update_o <= load_ok;
			if (load_ok) begin
				dac_code_o <= shift_reg[CODE_LSB +: CODE_BITS] & code_mask;
			end
		end
	end

	// edge choice only takes effect after the frame closes, never mid-frame
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			edge_sel_reg <= EDGE_RST;
		end else if (load_ok) begin
			edge_sel_reg <= shift_reg[EDGE_SEL_BIT];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			rise_capture_o <= EDGE_RST;
		end else begin
			rise_capture_o <= edge_sel_reg;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_frame_close;
		!frame_d_reg ##0 frame_n_s;
	endsequence

	// close of a frame that delivered all sixteen captures
	sequence s_full_close;
		s_frame_close ##0 (cnt_reg == CNT_FULL);
	endsequence

	a_update_on_close: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		s_full_close |=> dac_update_o)
		else $error("latch not updated at frame close");
	a_update_cause: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		dac_update_o |-> $past(frame_rise) && $past(cnt_reg) == CNT_FULL)
		else $error("update without full frame close");
	a_default_fall: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!edge_sel_reg && in_frame && sclk_fall |=> shift_reg[0] == $past(data_s))
		else $error("falling edge capture missed");
	a_rise_shift: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		edge_sel_reg && in_frame && sclk_rise |=> shift_reg[0] == $past(data_s))
		else $error("rising edge capture missed");
	a_rise_capture: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		edge_sel_reg && in_frame && sclk_fall |=> shift_reg == $past(shift_reg))
		else $error("shifted on wrong edge");
	a_idle_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		frame_n_s |=> shift_reg == $past(shift_reg))
		else $error("shift outside frame");
	a_count_limit: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		cnt_reg <= CNT_FULL)
		else $error("bit count overran");
	a_chain_msb: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		in_frame && launch_edge |=> chain_data_out_o == $past(shift_reg[FRAME_BITS-1]))
		else $error("chain output wrong bit");
	a_chain_edge: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$changed(chain_data_out_o) |-> $past(launch_edge))
		else $error("chain output moved off launch edge");
	a_code_range: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(dac_code_o & ~code_mask) == CODE_RST)
		else $error("code beyond converter range");
	a_code_load: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		s_full_close |=> dac_code_o == ($past(shift_reg[CODE_LSB +: CODE_BITS]) & code_mask))
		else $error("latch loaded with wrong word");
	a_code_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!load_ok |=> $stable(dac_code_o))
		else $error("latch moved without frame close");
	a_update_pulse: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		dac_update_o |=> !dac_update_o)
		else $error("update pulse longer than one cycle");
	a_short_refused: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		frame_rise && (cnt_reg != CNT_FULL) |=> !dac_update_o)
		else $error("short frame loaded the latch");
	a_mode_source: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$changed(edge_sel_reg) |-> $past(load_ok))
		else $error("capture edge changed mid-frame");
	a_mode_out: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		rise_capture_o == $past(edge_sel_reg))
		else $error("mode output does not follow capture edge");
endmodule
`default_nettype wire

// File: testbench/dsip_host.sv
`default_nettype none
module dsip_host (
	input  wire logic ref_clk_i,
	input  wire logic chain_i,
	output var  logic sclk_o,
	output var  logic frame_n_o,
	output var  logic sdata_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// serial master, msb first
	// ----------------------------------------
	logic chain_q[$];
	initial begin
		sclk_o = 1'b1;
		frame_n_o = 1'b1;
		sdata_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	// clock stands still between frames, parked opposite the capture edge
	task automatic send(input logic [31:0] w, input int n, input logic rise);
		sclk_o = ~rise;
		tick(dsip_pkg::LINK_HALF_CYC);
		frame_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdata_o = w[n-1-i];
			tick(dsip_pkg::LINK_HALF_CYC);
			chain_q.push_back(chain_i);
			sclk_o = rise;
			tick(dsip_pkg::LINK_HALF_CYC);
			sclk_o = ~rise;
		end
		tick(dsip_pkg::LINK_HALF_CYC);
		frame_n_o = 1'b1;
		// released data line must not keep the last bit
		sdata_o = ~sdata_o;
		tick(16);
	endtask
endmodule
`default_nettype wire

// File: testbench/tb_dac_serial_input_port.sv
`default_nettype none
module tb_dac_serial_input_port;
	timeunit 1ns;
	timeprecision 100ps;
	import dsip_pkg::*;
	// ----------------------------------------
	// bench for the 12-bit variant, wide variant alongside
	// ----------------------------------------
	localparam int unsigned DB = 12;
	logic                 ref_clk_i;
	logic                 rstn_i;
	logic                 sclk;
	logic                 frame_n;
	logic                 sdata;
	logic                 chain;
	logic                 upd;
	logic                 rise_cap;
	logic [CODE_BITS-1:0] code;
	logic [CODE_BITS-1:0] code_w;
	int                   errors;
	int                   num_checks;
	int                   n_upd;
	logic [31:0]          rng;
	dsip_host host (.ref_clk_i(ref_clk_i), .chain_i(chain), .sclk_o(sclk),
		.frame_n_o(frame_n), .sdata_o(sdata));
	dsip_port #(.DAC_BITS(DB)) uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sclk_i(sclk),
		.frame_n_i(frame_n), .serial_data_in_i(sdata), .chain_data_out_o(chain),
		.dac_code_o(code), .dac_update_o(upd), .rise_capture_o(rise_cap));
	dsip_port #(.DAC_BITS(CODE_BITS)) uut_wide (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.sclk_i(sclk), .frame_n_i(frame_n), .serial_data_in_i(sdata), .chain_data_out_o(),
		.dac_code_o(code_w), .dac_update_o(), .rise_capture_o());
	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	// counted mid-cycle so the pulse is read where it has settled
	always @(negedge ref_clk_i) if (upd === 1'b1) n_upd++;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic [CODE_BITS-1:0] exp_code(input logic [15:0] w, input int bits);
		return w[CODE_BITS-1:0] & CODE_BITS'((32'h1 << bits) - 32'h1);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// latch, pulse and mode only move on a full frame
	task automatic frame(input logic [31:0] w, input int n);
		logic [CODE_BITS-1:0] c0;
		logic [CODE_BITS-1:0] cw0;
		int                   u0;
		logic                 m0;
		c0 = code;
		cw0 = code_w;
		u0 = n_upd;
		m0 = rise_cap;
		host.chain_q.delete();
		host.send(w, n, m0);
		if (n >= 16) begin
			check(32'(code), 32'(exp_code(w[15:0], DB)));
			check(32'(code_w), 32'(exp_code(w[15:0], CODE_BITS)));
			check(n_upd, u0 + 1);
			check(32'(rise_cap), 32'(w[EDGE_SEL_BIT]));
			for (int i = 16; i < n; i++) begin
				check(32'(host.chain_q[i]), 32'(w[n+15-i]));
			end
		end else begin
			check(32'(code), 32'(c0));
			check(32'(code_w), 32'(cw0));
			check(n_upd, u0);
			check(32'(rise_cap), 32'(m0));
		end
	endtask
	initial begin
		rstn_i = 1'b0;
		errors = 0;
		num_checks = 0;
		n_upd = 0;
		rng = 32'h0001_4570;
		repeat (10) @(negedge ref_clk_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		check(32'({code, rise_cap, chain}), 32'h0);
		check(32'(code_w), 32'h0);
		frame(32'h0000_3FFF, 16);
		frame(32'h0000_0000, 16);
		for (int k = 0; k < 6; k++) begin
			rng = xs(rng);
			frame({16'h0, 1'b0, rng[14:0]}, 16);
		end
		frame(32'h0000_1234, 8);
		frame(32'h0000_8ABC, 16);
		for (int k = 0; k < 4; k++) begin
			rng = xs(rng);
			frame({rng[31:16], 1'b1, rng[14:0]}, 32);
		end
		rng = xs(rng);
		frame({16'h0, 1'b0, rng[14:0]}, 16);
		frame({rng[31:16], 1'b0, rng[14:0]}, 32);
		report_and_stop();
	end
	initial begin
		#300us;
		errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
